/* File: src/dual_timer.sv */
/*
 Two 16-bit timer/counters with time-base select, gating, four modes
 and overflow flags, reached over a simple 8-bit register port.
 Assumes reset, register port and ack inputs are synchronous to mclk; the event and gate pins
 are treated as asynchronous and resynchronised here.
*/
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dual_timer (
   input  wire logic       mclk,
   input  wire logic       reset,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       timer_zero_event_pin,
   input  wire logic       timer_one_event_pin,
   input  wire logic       external_interrupt_pin_zero,
   input  wire logic       external_interrupt_pin_one,
   input  wire logic       ovf_ack_zero,
   input  wire logic       ovf_ack_one,
   output logic            irq_zero,
   output logic            irq_one,
   output logic            timer_one_rollover
);

   // ***************************************************
   // Declarations
   // ***************************************************
   logic [7:0]   rdata_ff;
   logic         irq_zero_ff;
   logic         irq_one_ff;
   logic         t1_roll_ff;
   logic         run0_ff;
   logic         run1_ff;
   logic         ovf0_ff;
   logic         ovf1_ff;
   logic [7:0]   mode_ff;
   logic [2:0]   speed_ff;
   logic         clk12_ff;
   logic         ien0_ff;
   logic         ien1_ff;
   logic [7:0]   tl0_ff;
   logic [7:0]   th0_ff;
   logic [7:0]   tl1_ff;
   logic [7:0]   th1_ff;
   logic [3:0]   base_ff;

   logic [3:0]   nxt_base;
   logic [7:0]   nxt_tl0;
   logic [7:0]   nxt_th0;
   logic [7:0]   nxt_tl1;
   logic [7:0]   nxt_th1;
   logic [7:0]   nxt_rdata;
   logic         nxt_ovf0;
   logic         nxt_ovf1;

   logic         tick12;
   logic         tick6;
   logic         tick0;
   logic         tick1;
   tmr_pkg::tmode_e m0;
   tmr_pkg::tmode_e m1;
   logic         ct0;
   logic         ct1;
   logic         gate0;
   logic         gate1;
   logic         split0;
   logic         en0;
   logic         en1;
   logic         adv0;
   logic         adv1;
   logic         adv0_hi;
   logic [16:0]  step0;
   logic [16:0]  step1;
   logic         hw_ovf0;
   logic         hw_ovf1;
   logic         roll1;
   logic         wr_ctrl;

   pin_sense_if ev0 ();
   pin_sense_if ev1 ();
   pin_sense_if gp0 ();
   pin_sense_if gp1 ();

   // ***************************************************
   // Pin conditioning
   // ***************************************************
   pin_sense u_ev0 (.mclk(mclk), .reset(reset), .raw(timer_zero_event_pin),        .ps(ev0));
   pin_sense u_ev1 (.mclk(mclk), .reset(reset), .raw(timer_one_event_pin),         .ps(ev1));
   pin_sense u_gp0 (.mclk(mclk), .reset(reset), .raw(external_interrupt_pin_zero), .ps(gp0));
   pin_sense u_gp1 (.mclk(mclk), .reset(reset), .raw(external_interrupt_pin_one),  .ps(gp1));

   // ***************************************************
   // One counting step for a 13, 16 or 8-bit counter
   // ***************************************************
   // Result is {overflow, high byte, low byte}
   function automatic logic [16:0] step (
      input tmr_pkg::tmode_e m,
      input logic [7:0]      hi,
      input logic [7:0]      lo
   );
      logic [13:0] c13;
      logic [16:0] c16;
      logic [8:0]  c8;
      c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      c16 = {1'b0, hi, lo} + 17'h00001;
      c8  = {1'b0, lo} + 9'h001;
      unique case (m)
         tmr_pkg::MODE_13BIT:   step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
         tmr_pkg::MODE_16BIT:   step = c16;
         tmr_pkg::MODE_RELOAD8: step = c8[8] ? {1'b1, hi, hi} : {1'b0, hi, c8[7:0]};
         tmr_pkg::MODE_SPLIT:   step = {c8[8], hi, c8[7:0]};
      endcase
   endfunction : step

   // ***************************************************
   // Time base
   // ***************************************************
   always_comb begin
      tick12   = (base_ff == tmr_pkg::DIV_STD - 4'h1);
      tick6    = tick12 || (base_ff == tmr_pkg::DIV_TURBO - 4'h1);
      nxt_base = tick12 ? 4'h0 : base_ff + 4'h1;
      // Speed bits count only in six-clock core setting
      tick0    = (speed_ff[0] && !clk12_ff) ? tick6 : tick12;
      tick1    = (speed_ff[1] && !clk12_ff) ? tick6 : tick12;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         base_ff <= 4'h0;
      end else begin
         base_ff <= nxt_base;
      end
   end

   // ***************************************************
   // Mode decode and count enables
   // ***************************************************
   always_comb begin
      m0     = tmr_pkg::tmode_e'(mode_ff[tmr_pkg::MODE_T0_LSB +: 2]);
      m1     = tmr_pkg::tmode_e'(mode_ff[tmr_pkg::MODE_T1_LSB +: 2]);
      ct0    = mode_ff[tmr_pkg::MODE_T0_CT];
      ct1    = mode_ff[tmr_pkg::MODE_T1_CT];
      gate0  = mode_ff[tmr_pkg::MODE_T0_GATE];
      gate1  = mode_ff[tmr_pkg::MODE_T1_GATE];
      split0 = (m0 == tmr_pkg::MODE_SPLIT);
      en0    = run0_ff && (!gate0 || gp0.level);
      // Timer one loses its run bit to timer zero while split
      en1    = (split0 || run1_ff) && (!gate1 || gp1.level)
               && (m1 != tmr_pkg::MODE_SPLIT);
      adv0   = en0 && (ct0 ? ev0.fall : tick0);
      adv1   = en1 && (ct1 ? ev1.fall : tick1);
      adv0_hi = split0 && run1_ff && tick0;
      step0  = step(m0, th0_ff, tl0_ff);
      step1  = step(m1, th1_ff, tl1_ff);
   end

   // ***************************************************
   // Count registers
   // ***************************************************
   always_comb begin
      nxt_tl0 = tl0_ff;
      nxt_th0 = th0_ff;
      nxt_tl1 = tl1_ff;
      nxt_th1 = th1_ff;
      hw_ovf0 = 1'b0;
      hw_ovf1 = 1'b0;
      roll1   = 1'b0;
      if (adv0) begin
         nxt_tl0 = step0[7:0];
         hw_ovf0 = step0[16];
         if (!split0) begin
            nxt_th0 = step0[15:8];
         end
      end
      if (adv0_hi) begin
         nxt_th0 = th0_ff + 8'h01;
         hw_ovf1 = (th0_ff == 8'hff);
      end
      if (adv1) begin
         nxt_tl1 = step1[7:0];
         nxt_th1 = step1[15:8];
         roll1   = step1[16];
         if (!split0) begin
            hw_ovf1 = step1[16];
         end
      end
      // Software writes win over a count in the same cycle
      if (wr) begin
         unique case (addr)
            tmr_pkg::ADDR_T0_LO: nxt_tl0 = wdata;
            tmr_pkg::ADDR_T0_HI: nxt_th0 = wdata;
            tmr_pkg::ADDR_T1_LO: nxt_tl1 = wdata;
            tmr_pkg::ADDR_T1_HI: nxt_th1 = wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         tl0_ff <= tmr_pkg::RST_BYTE;
         th0_ff <= tmr_pkg::RST_BYTE;
         tl1_ff <= tmr_pkg::RST_BYTE;
         th1_ff <= tmr_pkg::RST_BYTE;
      end else begin
         tl0_ff <= nxt_tl0;
         th0_ff <= nxt_th0;
         tl1_ff <= nxt_tl1;
         th1_ff <= nxt_th1;
      end
   end

   // ***************************************************
   // Overflow flags
   // ***************************************************
   always_comb begin
      wr_ctrl  = wr && (addr == tmr_pkg::ADDR_CTRL);
      nxt_ovf0 = ovf0_ff;
      nxt_ovf1 = ovf1_ff;
      if (ovf_ack_zero) begin
         nxt_ovf0 = 1'b0;
      end
      if (ovf_ack_one) begin
         nxt_ovf1 = 1'b0;
      end
      if (wr_ctrl) begin
         nxt_ovf0 = wdata[tmr_pkg::CTRL_OVF0];
         nxt_ovf1 = wdata[tmr_pkg::CTRL_OVF1];
      end
      // Hardware set beats any clear in the same cycle
      if (hw_ovf0) begin
         nxt_ovf0 = 1'b1;
      end
      if (hw_ovf1) begin
         nxt_ovf1 = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         ovf0_ff <= 1'b0;
         ovf1_ff <= 1'b0;
      end else begin
         ovf0_ff <= nxt_ovf0;
         ovf1_ff <= nxt_ovf1;
      end
   end

   // ***************************************************
   // Control and configuration registers
   // ***************************************************
   always_ff @(posedge mclk) begin
      if (reset) begin
         run0_ff <= 1'b0;
         run1_ff <= 1'b0;
      end else if (wr_ctrl) begin
         run0_ff <= wdata[tmr_pkg::CTRL_RUN0];
         run1_ff <= wdata[tmr_pkg::CTRL_RUN1];
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         mode_ff <= tmr_pkg::RST_BYTE;
      end else if (wr && (addr == tmr_pkg::ADDR_MODE)) begin
         mode_ff <= wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         speed_ff <= tmr_pkg::RST_SPEED;
      end else if (wr && (addr == tmr_pkg::ADDR_CLK)) begin
         speed_ff <= wdata[tmr_pkg::CLK_SPEED_LSB +: 3];
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         clk12_ff <= 1'b0;
         ien0_ff  <= 1'b0;
         ien1_ff  <= 1'b0;
      end else if (wr && (addr == tmr_pkg::ADDR_OPT)) begin
         clk12_ff <= wdata[tmr_pkg::OPT_CLK12];
         ien0_ff  <= wdata[tmr_pkg::OPT_IEN0];
         ien1_ff  <= wdata[tmr_pkg::OPT_IEN1];
      end
   end

   // ***************************************************
   // Interrupt requests and rollover pulse
   // ***************************************************
   always_ff @(posedge mclk) begin
      if (reset) begin
         irq_zero_ff <= 1'b0;
         irq_one_ff  <= 1'b0;
         t1_roll_ff  <= 1'b0;
      end else begin
         irq_zero_ff <= ovf0_ff && ien0_ff;
         irq_one_ff  <= ovf1_ff && ien1_ff;
         t1_roll_ff  <= roll1;
      end
   end

   // ***************************************************
   // Read port
   // ***************************************************
   always_comb begin
      nxt_rdata = 8'h00;
      if (rd) begin
         unique case (addr)
            tmr_pkg::ADDR_CTRL:  nxt_rdata = {ovf1_ff, run1_ff, ovf0_ff, run0_ff, 4'h0};
            tmr_pkg::ADDR_MODE:  nxt_rdata = mode_ff;
            tmr_pkg::ADDR_T0_LO: nxt_rdata = tl0_ff;
            tmr_pkg::ADDR_T0_HI: nxt_rdata = th0_ff;
            tmr_pkg::ADDR_T1_LO: nxt_rdata = tl1_ff;
            tmr_pkg::ADDR_T1_HI: nxt_rdata = th1_ff;
            tmr_pkg::ADDR_CLK:   nxt_rdata = {2'h0, speed_ff, 3'h0};
            tmr_pkg::ADDR_OPT:   nxt_rdata = {4'h0, clk12_ff, 1'b0, ien1_ff, ien0_ff};
            default:             nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata              = rdata_ff;
   assign irq_zero           = irq_zero_ff;
   assign irq_one            = irq_one_ff;
   assign timer_one_rollover = t1_roll_ff;

endmodule : dual_timer
`default_nettype wire

/* File: src/tmr_pkg.sv */
/*
 Constants shared by the dual timer/counter: register offsets, field
 positions, values after reset, time-base counts and the mode encoding.
 Assumes an 8-bit register port with an 8-bit address.
*/
package tmr_pkg;

   // ***************************************************
   // Register offsets
   // ***************************************************
   localparam logic [7:0] ADDR_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_MODE  = 8'h01;
   localparam logic [7:0] ADDR_T0_LO = 8'h02;
   localparam logic [7:0] ADDR_T0_HI = 8'h03;
   localparam logic [7:0] ADDR_T1_LO = 8'h04;
   localparam logic [7:0] ADDR_T1_HI = 8'h05;
   localparam logic [7:0] ADDR_CLK   = 8'h06;
   localparam logic [7:0] ADDR_OPT   = 8'h07;

   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int CTRL_RUN0  = 4;
   localparam int CTRL_OVF0  = 5;
   localparam int CTRL_RUN1  = 6;
   localparam int CTRL_OVF1  = 7;
   localparam int MODE_T0_LSB  = 0;
   localparam int MODE_T0_CT   = 2;
   localparam int MODE_T0_GATE = 3;
   localparam int MODE_T1_LSB  = 4;
   localparam int MODE_T1_CT   = 6;
   localparam int MODE_T1_GATE = 7;
   localparam int CLK_SPEED_LSB = 3;
   localparam int OPT_IEN0   = 0;
   localparam int OPT_IEN1   = 1;
   localparam int OPT_CLK12  = 3;

   // ***************************************************
   // Reset values and time base
   // ***************************************************
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [2:0] RST_SPEED = 3'h0;
   localparam logic [3:0] DIV_STD   = 4'hc;
   localparam logic [3:0] DIV_TURBO = 4'h6;

   typedef enum logic [1:0] {
      MODE_13BIT,
      MODE_16BIT,
      MODE_RELOAD8,
      MODE_SPLIT
   } tmode_e;

endpackage : tmr_pkg

/* File: src/pin_sense_if.sv */
/*
 Carrier for one conditioned input pin: synchronised level and a
 one-cycle falling-edge pulse. Assumes a single mclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface pin_sense_if;
   logic level;
   logic fall;
   modport src (output level, output fall);
   modport dst (input level, input fall);
endinterface : pin_sense_if
`default_nettype wire

/* File: src/pin_sense.sv */
/*
 Two-stage synchroniser with falling-edge detection for one pin.
 Assumes the pin is idle high and mclk is the only clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sense (
   input  wire logic  mclk,
   input  wire logic  reset,
   input  wire logic  raw,
   pin_sense_if.src   ps
);

   logic sync1_ff;
   logic sync2_ff;
   logic prev_ff;

   // ***************************************************
   // Synchroniser and edge history
   // ***************************************************
   always_ff @(posedge mclk) begin
      if (reset) begin
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
         prev_ff  <= 1'b1;
      end else begin
         sync1_ff <= raw;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   assign ps.level = sync2_ff;
   assign ps.fall  = prev_ff & ~sync2_ff;

endmodule : pin_sense
`default_nettype wire

/* File: verif/dual_timer_properties.sv */
/* Concurrent checks on the dual timer ports, attached by bind.
   Assumes one mclk domain and the register map of tmr_pkg. */
`timescale 1ns/1ps
`default_nettype none
module dual_timer_checker (
   input wire logic       mclk,
   input wire logic       reset,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       timer_zero_event_pin,
   input wire logic       timer_one_event_pin,
   input wire logic       external_interrupt_pin_zero,
   input wire logic       external_interrupt_pin_one,
   input wire logic       ovf_ack_zero,
   input wire logic       ovf_ack_one,
   input wire logic       irq_zero,
   input wire logic       irq_one,
   input wire logic       timer_one_rollover
);
   // ************************
   // Shadow of written controls
   // ************************
   logic       wr_ctrl;
   logic       run0_ff, run1_ff, en0_ff, en1_ff, split_ff, frz_ff;
   logic [2:0] spd_ff;
   assign wr_ctrl = wr && (addr == tmr_pkg::ADDR_CTRL);
   always_ff @(posedge mclk) begin
      if (reset) begin
         {run1_ff, run0_ff, en1_ff, en0_ff, split_ff, frz_ff} <= 6'h00;
         spd_ff <= 3'h0;
      end else if (wr_ctrl) begin
         {run1_ff, run0_ff} <= {wdata[6], wdata[4]};
      end else if (wr && addr == tmr_pkg::ADDR_OPT) begin
         {en1_ff, en0_ff} <= wdata[1:0];
      end else if (wr && addr == tmr_pkg::ADDR_MODE) begin
         split_ff <= (wdata[1:0] == 2'h3);
         frz_ff <= (wdata[5:4] == 2'h3);
      end else if (wr && addr == tmr_pkg::ADDR_CLK) begin
         spd_ff <= wdata[5:3];
      end
   end
   // ************************
   // Assertions
   // ************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_flag0_wr; wr_ctrl && wdata[5] && en0_ff; endsequence
   sequence s_flag1_wr; wr_ctrl && wdata[7] && en1_ff; endsequence
   sequence s_ack0; ovf_ack_zero && !run0_ff && !wr_ctrl; endsequence
   sequence s_t1_off; !run1_ff && !split_ff; endsequence
   AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   AST_CLK_READ: assert property (rd && addr == tmr_pkg::ADDR_CLK |=> rdata == {2'h0, spd_ff, 3'h0})
      else $error("clock control read back wrong");
   AST_IRQ0_NEEDS_EN: assert property (irq_zero |-> $past(en0_ff))
      else $error("request zero while disabled");
   AST_IRQ0_SET: assert property (s_flag0_wr |-> ##2 irq_zero)
      else $error("flag zero set by write gave no request");
   AST_IRQ1_SET: assert property (s_flag1_wr |-> ##2 irq_one)
      else $error("flag one set by write gave no request");
   AST_ACK0_CLEAR: assert property (s_ack0 |-> ##2 !irq_zero)
      else $error("acknowledge left request zero up");
   AST_ROLL_FLAG: assert property (timer_one_rollover && en1_ff && $past(en1_ff) && $past(en1_ff, 2)
      && !split_ff && !$past(split_ff, 2) |-> ##[0:1] irq_one)
      else $error("timer one wrap gave no request");
   AST_T1_FROZEN: assert property (frz_ff && $past(frz_ff, 2) |-> !timer_one_rollover)
      else $error("timer one wrapped while frozen");
   AST_T1_IDLE: assert property (s_t1_off [*3] |-> !timer_one_rollover)
      else $error("timer one wrapped while stopped");
endmodule : dual_timer_checker
bind dual_timer dual_timer_checker u_chk (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .timer_zero_event_pin(timer_zero_event_pin),
   .timer_one_event_pin(timer_one_event_pin), .external_interrupt_pin_zero(external_interrupt_pin_zero),
   .external_interrupt_pin_one(external_interrupt_pin_one), .ovf_ack_zero(ovf_ack_zero),
   .ovf_ack_one(ovf_ack_one), .irq_zero(irq_zero), .irq_one(irq_one),
   .timer_one_rollover(timer_one_rollover));
`default_nettype wire

/* File: verif/pin_partner.sv */
/* Model of the outside party on the event and gate pins.
   Assumes pins idle high and move just after a rising mclk. */
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
   input  wire logic mclk,
   output logic      ev0,
   output logic      ev1,
   output logic      gate0,
   output logic      gate1
);
   // ************************
   // Pin drive
   // ************************
   initial begin
      {ev0, ev1, gate0, gate1} = 4'hf;
   end
   task automatic set_gate(input int idx, input logic v);
      @(posedge mclk);
      if (idx == 0) gate0 <= v;
      else gate1 <= v;
   endtask : set_gate
   // Gap is both low and high time in cycles, two or more
   task automatic falls(input int idx, input int n, input int gap);
      repeat (n) begin
         repeat (gap) @(posedge mclk);
         if (idx == 0) ev0 <= 1'b0;
         else ev1 <= 1'b0;
         repeat (gap) @(posedge mclk);
         if (idx == 0) ev0 <= 1'b1;
         else ev1 <= 1'b1;
      end
      repeat (gap) @(posedge mclk);
   endtask : falls
endmodule : pin_partner
`default_nettype wire

/* File: verif/testbench.sv */
/* Self-checking bench for dual_timer: register tasks and scenarios.
   Assumes the pin partner model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ************************
   // Bench
   // ************************
   logic       mclk, reset, wr, rd, ack0, ack1, ev0, ev1, gate0, gate1, irq0, irq1, roll;
   logic [7:0] addr, wdata, rdata, got;
   int         err_total, tests_run, cycles;
   dual_timer dut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .timer_zero_event_pin(ev0), .timer_one_event_pin(ev1),
      .external_interrupt_pin_zero(gate0), .external_interrupt_pin_one(gate1),
      .ovf_ack_zero(ack0), .ovf_ack_one(ack1), .irq_zero(irq0), .irq_one(irq1),
      .timer_one_rollover(roll));
   pin_partner pins (.mclk(mclk), .ev0(ev0), .ev1(ev1), .gate0(gate0), .gate1(gate1));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         report_and_stop;
      end
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      tests_run++;
      if (seen !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
         err_total++;
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg
   task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
      rd_reg(a, got);
      chk(what, exp, got);
   endtask : rchk
   task automatic ack(input logic one);
      @(posedge mclk);
      {ack1, ack0} <= one ? 2'h2 : 2'h1;
      @(posedge mclk);
      {ack1, ack0} <= 2'h0;
   endtask : ack
   task automatic wait_flag(input int b);
      int n;
      n = 0;
      got = 8'h00;
      while (got[b] !== 1'b1 && n < 60) begin
         rd_reg(tmr_pkg::ADDR_CTRL, got);
         n++;
      end
      chk("flag wait", 8'h01, {7'h00, got[b]});
   endtask : wait_flag
   // ************************
   // Scenarios
   // ************************
   task automatic t_reset;
      rchk("clock control", tmr_pkg::ADDR_CLK, 8'h00);
      rchk("mode", tmr_pkg::ADDR_MODE, 8'h00);
      wr_reg(8'h20, 8'hff);
      rchk("unmapped", 8'h20, 8'h00);
   endtask : t_reset
   task automatic t_rate(input logic [7:0] clk, input logic [7:0] opt, input logic [7:0] exp);
      logic [7:0] first;
      wr_reg(tmr_pkg::ADDR_CLK, clk);
      wr_reg(tmr_pkg::ADDR_OPT, opt);
      wr_reg(tmr_pkg::ADDR_MODE, 8'h01);
      wr_reg(tmr_pkg::ADDR_T0_LO, 8'h00);
      wr_reg(tmr_pkg::ADDR_CTRL, 8'h10);
      rd_reg(tmr_pkg::ADDR_T0_LO, first);
      repeat (58) @(posedge mclk);
      rd_reg(tmr_pkg::ADDR_T0_LO, got);
      wr_reg(tmr_pkg::ADDR_CTRL, 8'h00);
      chk("ticks in 60 cycles", exp, got - first);
   endtask : t_rate
   task automatic t_wrap(input logic [7:0] m, hi, lo, ehi, elo);
      wr_reg(tmr_pkg::ADDR_OPT, 8'h01);
      wr_reg(tmr_pkg::ADDR_MODE, m);
      wr_reg(tmr_pkg::ADDR_T0_HI, hi);
      wr_reg(tmr_pkg::ADDR_T0_LO, lo);
      wr_reg(tmr_pkg::ADDR_CTRL, 8'h10);
      wait_flag(5);
      wr_reg(tmr_pkg::ADDR_CTRL, 8'h20);
      rchk("high byte", tmr_pkg::ADDR_T0_HI, ehi);
      rchk("low byte", tmr_pkg::ADDR_T0_LO, elo);
      chk("request zero", 8'h01, {7'h00, irq0});
      ack(1'b0);
      rchk("control after ack", tmr_pkg::ADDR_CTRL, 8'h00);
   endtask : t_wrap
   task automatic t_events;
      wr_reg(tmr_pkg::ADDR_MODE, 8'hdd);
      for (int i = 0; i < 2; i++) begin
         logic [7:0] lo_a;
         lo_a = i ? tmr_pkg::ADDR_T1_LO : tmr_pkg::ADDR_T0_LO;
         wr_reg(lo_a, 8'h00);
         pins.set_gate(i, 1'b0);
         wr_reg(tmr_pkg::ADDR_CTRL, 8'h50);
         pins.falls(i, 4, 2);
         pins.set_gate(i, 1'b1);
         pins.falls(i, 3, 3);
         repeat (4) @(posedge mclk);
         rchk("event count", lo_a, 8'h03);
         wr_reg(tmr_pkg::ADDR_CTRL, 8'h00);
      end
   endtask : t_events
   task automatic t_reload;
      int n;
      logic rolled;
      wr_reg(tmr_pkg::ADDR_OPT, 8'h02);
      wr_reg(tmr_pkg::ADDR_MODE, 8'h20);
      wr_reg(tmr_pkg::ADDR_T1_HI, 8'hfe);
      wr_reg(tmr_pkg::ADDR_T1_LO, 8'hfe);
      wr_reg(tmr_pkg::ADDR_CTRL, 8'h40);
      n = 0;
      rolled = 1'b0;
      do begin
         @(posedge mclk);
         #1;
         rolled = rolled | roll;
         n++;
      end while (irq1 !== 1'b1 && n < 60);
      chk("request one", 8'h01, {7'h00, irq1});
      chk("rollover pulse", 8'h01, {7'h00, rolled});
      wr_reg(tmr_pkg::ADDR_CTRL, 8'h80);
      rchk("reload low", tmr_pkg::ADDR_T1_LO, 8'hfe);
      rchk("reload high", tmr_pkg::ADDR_T1_HI, 8'hfe);
      ack(1'b1);
      rchk("control after ack", tmr_pkg::ADDR_CTRL, 8'h00);
   endtask : t_reload
   task automatic t_swflag;
      wr_reg(tmr_pkg::ADDR_OPT, 8'h03);
      wr_reg(tmr_pkg::ADDR_CTRL, 8'ha0);
      rchk("flags by write", tmr_pkg::ADDR_CTRL, 8'ha0);
      chk("requests", 8'h03, {6'h00, irq1, irq0});
      wr_reg(tmr_pkg::ADDR_OPT, 8'h00);
      repeat (2) @(posedge mclk);
      #1;
      chk("requests masked", 8'h00, {6'h00, irq1, irq0});
      wr_reg(tmr_pkg::ADDR_CTRL, 8'h00);
      rchk("flags cleared", tmr_pkg::ADDR_CTRL, 8'h00);
   endtask : t_swflag
   task automatic t_mode3;
      wr_reg(tmr_pkg::ADDR_MODE, 8'h30);
      wr_reg(tmr_pkg::ADDR_T1_LO, 8'h10);
      wr_reg(tmr_pkg::ADDR_CTRL, 8'h40);
      repeat (40) @(posedge mclk);
      rchk("frozen count", tmr_pkg::ADDR_T1_LO, 8'h10);
      wr_reg(tmr_pkg::ADDR_MODE, 8'h03);
      wr_reg(tmr_pkg::ADDR_T0_HI, 8'hff);
      wr_reg(tmr_pkg::ADDR_T0_LO, 8'h00);
      wait_flag(7);
      chk("split flags", 8'hc0, got);
      rchk("split low byte", tmr_pkg::ADDR_T0_LO, 8'h00);
      wr_reg(tmr_pkg::ADDR_CTRL, 8'h00);
      wr_reg(tmr_pkg::ADDR_MODE, 8'h00);
   endtask : t_mode3
   initial begin
      {reset, wr, rd, ack0, ack1} = 5'h10;
      {addr, wdata} = 16'h0000;
      {err_total, tests_run} = {32'd0, 32'd0};
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      t_reset;
      t_rate(8'h08, 8'h00, 8'h0a);
      t_rate(8'h08, 8'h08, 8'h05);
      t_rate(8'h10, 8'h00, 8'h05);
      t_rate(8'h00, 8'h00, 8'h05);
      t_wrap(8'h00, 8'hff, 8'hfe, 8'h00, 8'he0);
      t_wrap(8'h01, 8'hff, 8'hff, 8'h00, 8'h00);
      t_wrap(8'h02, 8'h7a, 8'hff, 8'h7a, 8'h7a);
      t_events;
      t_reload;
      t_swflag;
      t_mode3;
      report_and_stop;
   end
endmodule : testbench
`default_nettype wire
